// *** rtl/raee_core.sv ***
// Contract
// - reset outranks every interrupt including non-maskable request
// - reset handling starts as soon as external reset is released
// - watchdog overflow runs the same reset sequence as the pin
// - mask bit blocks all but non-maskable and address break
// - interrupt entry waits until current instruction completes
// - highest-priority pending request is serviced first
// - vector numbers fixed: 0,3,5,6-10,11-18,19-43
// - vectors 1, 2, 4 reserved, never given to user sources
// - reset from pin low, power-on detector, or watchdog overflow
// - any reset halts processing and holds until source removed
// - first reset step initialises state and sets mask bit
// - read reset vector at 0000/0001, load counter, start fetching
// - all interrupts masked after reset until first instruction ran
// - entry saves counter and flags in 4 states, vector in 2
module raee_core
	import raee_pkg::*;
(
	// clock and reset
	input  wire logic                  mclk,
	input  wire logic                  rst_b,
	// reset sources
	input  wire logic                  externalResetInputLow_b,
	input  wire logic                  powerOnDetect,
	input  wire logic                  watchdogOverflow,
	// interrupt sources
	input  wire logic                  nmiReq,
	input  wire logic                  addrBreakReq,
	input  wire logic [NUM_EXT-1:0]    extReq,
	input  wire logic [NUM_WAKE-1:0]   wakeReq,
	input  wire logic [NUM_INTERNAL-1:0] internalReq,
	// sequencer side
	input  wire logic                  instrDone,
	input  wire logic                  maskWrEn,
	input  wire logic                  maskWrVal,
	input  wire logic [ADDR_W-1:0]     vecData,
	output logic                       coreHalt,
	output logic                       initPulse,
	output logic                       stackSave,
	output logic                       vecRead,
	output logic [ADDR_W-1:0]          vecAddr,
	output logic                       pcLoad,
	output logic [ADDR_W-1:0]          pcValue,
	output logic                       intMask,
	output logic [VEC_W-1:0]           activeVec
);
	// ==========================================
	// reset sources
	logic resetReq;
	assign resetReq = !externalResetInputLow_b || powerOnDetect || watchdogOverflow;

	// ==========================================
	// request masking and priority
	logic [NUM_MASKABLE-1:0] maskable;
	logic                    maskHit;
	logic [VEC_W-1:0]        maskVec;
	logic                    firstDone_ff, nxt_firstDone;
	logic                    intMask_ff, nxt_intMask;
	// mask bit gates maskable group only
	assign maskable = (intMask_ff || !firstDone_ff) ? '0 : {internalReq, wakeReq, extReq};

	raee_prio u_prio
	(
		.reqVec (maskable),
		.hit    (maskHit),
		.vecNum (maskVec)
	);

	logic             anyReq;
	logic [VEC_W-1:0] pickVec;
	// fixed vector numbers, 1, 2, 4 never chosen
	always_comb
	begin
		anyReq = 1'b1;
		pickVec = VEC_NMI;
		if (!firstDone_ff)
			anyReq = 1'b0;
		else if (nmiReq)
			pickVec = VEC_NMI;
		else if (addrBreakReq)
			pickVec = VEC_ADDR_BREAK;
		else if (maskHit)
			pickVec = maskVec;
		else
			anyReq = 1'b0;
	end

	// ==========================================
	// entry sequencer
	raee_state_t      state_ff, nxt_state;
	logic [2:0]       cnt_ff, nxt_cnt;
	logic [VEC_W-1:0] vec_ff, nxt_vec;
	logic [ADDR_W-1:0] pc_ff, nxt_pc;
	logic             pcLoad_ff, nxt_pcLoad;

	always_comb
	begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_vec = vec_ff;
		nxt_pc = pc_ff;
		nxt_pcLoad = 1'b0;
		nxt_intMask = intMask_ff;
		nxt_firstDone = firstDone_ff;
		if (maskWrEn && state_ff == RAEE_RUN)
			nxt_intMask = maskWrVal;
		// reset first, hold while source present
		if (resetReq)
		begin
			nxt_state = RAEE_RESET;
			nxt_cnt = CNT_ZERO;
			nxt_vec = VEC_RESET;
			nxt_intMask = 1'b1;
			nxt_firstDone = 1'b0;
		end
		else
		begin
			unique case (state_ff)
				RAEE_RESET:
				begin
					nxt_state = RAEE_INIT;
					nxt_intMask = 1'b1;
				end
				RAEE_INIT:
				begin
					nxt_state = RAEE_FETCH;
					nxt_cnt = CNT_ZERO;
				end
				RAEE_RUN:
				begin
					if (instrDone)
						nxt_firstDone = 1'b1;
					if (instrDone && anyReq)
					begin
						nxt_state = RAEE_SAVE;
						nxt_cnt = CNT_ZERO;
						nxt_vec = pickVec;
					end
				end
				RAEE_SAVE:
				begin
					nxt_cnt = cnt_ff + CNT_ONE;
					if (cnt_ff == SAVE_LAST)
					begin
						nxt_state = RAEE_FETCH;
						nxt_cnt = CNT_ZERO;
						nxt_intMask = 1'b1;
					end
				end
				RAEE_FETCH:
				begin
					nxt_cnt = cnt_ff + CNT_ONE;
					if (cnt_ff == FETCH_LAST)
					begin
						nxt_pc = vecData;
						nxt_pcLoad = 1'b1;
						nxt_state = RAEE_RUN;
						nxt_cnt = CNT_ZERO;
					end
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_ff <= RAEE_RESET;
			cnt_ff <= CNT_ZERO;
			vec_ff <= VEC_RESET;
			pc_ff <= RESET_VEC_ADDR;
			pcLoad_ff <= 1'b0;
			intMask_ff <= 1'b1;
			firstDone_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			vec_ff <= nxt_vec;
			pc_ff <= nxt_pc;
			pcLoad_ff <= nxt_pcLoad;
			intMask_ff <= nxt_intMask;
			firstDone_ff <= nxt_firstDone;
		end
	end

	// ==========================================
	// outputs
	assign coreHalt = (state_ff != RAEE_RUN);
	assign initPulse = (state_ff == RAEE_INIT);
	assign stackSave = (state_ff == RAEE_SAVE);
	assign vecRead = (state_ff == RAEE_FETCH);
	// byte address is twice the vector number
	assign vecAddr = {{(ADDR_W-VEC_W-1){1'b0}}, vec_ff, 1'b0};
	assign pcLoad = pcLoad_ff;
	assign pcValue = pc_ff;
	assign intMask = intMask_ff;
	assign activeVec = vec_ff;

	// ==========================================
	// checks
	property p_resetWins;
		@(posedge mclk) disable iff (!rst_b) resetReq |=> state_ff == RAEE_RESET;
	endproperty
	a_resetWins: assert property (p_resetWins) else $error("reset did not win");

	property p_release;
		@(posedge mclk) disable iff (!rst_b || resetReq)
			state_ff == RAEE_RESET && !resetReq |=> state_ff == RAEE_INIT ##1 vecRead && vecAddr == RESET_VEC_ADDR;
	endproperty
	a_release: assert property (p_release) else $error("reset release sequence wrong");

	property p_wdog;
		@(posedge mclk) disable iff (!rst_b) watchdogOverflow |=> state_ff == RAEE_RESET && intMask_ff;
	endproperty
	a_wdog: assert property (p_wdog) else $error("watchdog reset not taken");

	property p_maskBlocks;
		@(posedge mclk) disable iff (!rst_b)
			state_ff == RAEE_RUN && intMask_ff && !nmiReq && !addrBreakReq && !resetReq |=> state_ff != RAEE_SAVE;
	endproperty
	a_maskBlocks: assert property (p_maskBlocks) else $error("masked request taken");

	property p_boundary;
		@(posedge mclk) disable iff (!rst_b) state_ff == RAEE_RUN && !instrDone |=> state_ff != RAEE_SAVE;
	endproperty
	a_boundary: assert property (p_boundary) else $error("entry without instruction end");

	property p_nmiFirst;
		@(posedge mclk) disable iff (!rst_b)
			state_ff == RAEE_RUN && instrDone && nmiReq && firstDone_ff && !resetReq |=> activeVec == VEC_NMI;
	endproperty
	a_nmiFirst: assert property (p_nmiFirst) else $error("nmi not first");

	property p_reserved;
		@(posedge mclk) disable iff (!rst_b) stackSave |-> activeVec != 6'h01 && activeVec != 6'h02 && activeVec != 6'h04;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved vector used");

	property p_timing;
		@(posedge mclk) disable iff (!rst_b || resetReq)
			$rose(stackSave) |-> stackSave [*4] ##1 vecRead [*2] ##1 pcLoad;
	endproperty
	a_timing: assert property (p_timing) else $error("entry timing wrong");

	property p_pcLoad;
		@(posedge mclk) disable iff (!rst_b) pcLoad |-> pcValue == $past(vecData);
	endproperty
	a_pcLoad: assert property (p_pcLoad) else $error("counter not loaded from vector");
endmodule

// *** rtl/raee_pkg.sv ***
package raee_pkg;
	// ==========================================
	// vector numbers and table shape
	localparam int unsigned VEC_W = 6;
	localparam logic [VEC_W-1:0] VEC_RESET = 6'h00;
	localparam logic [VEC_W-1:0] VEC_NMI = 6'h03;
	localparam logic [VEC_W-1:0] VEC_ADDR_BREAK = 6'h05;
	localparam logic [VEC_W-1:0] VEC_EXT_FIRST = 6'h06;
	localparam logic [VEC_W-1:0] VEC_WAKE_FIRST = 6'h0b;
	localparam logic [VEC_W-1:0] VEC_INT_FIRST = 6'h13;
	localparam int unsigned NUM_EXT = 5;
	localparam int unsigned NUM_WAKE = 8;
	localparam int unsigned NUM_INTERNAL = 25;
	// maskable sources in priority order: ext 0..4, wakeup 0..7, internal 0..24
	localparam int unsigned NUM_MASKABLE = NUM_EXT + NUM_WAKE + NUM_INTERNAL;
	localparam int unsigned ADDR_W = 16;
	localparam logic [ADDR_W-1:0] RESET_VEC_ADDR = 16'h0000;
	// ==========================================
	// entry timing in states
	localparam int unsigned SAVE_STATES = 4;
	localparam int unsigned FETCH_STATES = 2;
	localparam logic [2:0] SAVE_LAST = 3'h3;
	localparam logic [2:0] FETCH_LAST = 3'h1;
	localparam logic [2:0] CNT_ZERO = 3'h0;
	localparam logic [2:0] CNT_ONE = 3'h1;
	typedef enum logic [2:0] {RAEE_RESET, RAEE_INIT, RAEE_RUN, RAEE_SAVE, RAEE_FETCH} raee_state_t;
endpackage

// *** rtl/raee_prio.sv ***
module raee_prio
	import raee_pkg::*;
(
	// masked request vector, index 0 highest
	input  wire logic [NUM_MASKABLE-1:0] reqVec,
	// result
	output logic                         hit,
	output logic [VEC_W-1:0]             vecNum
);
	// ==========================================
	// fixed priority: lowest index wins
	always_comb
	begin
		hit = 1'b0;
		vecNum = VEC_RESET;
		for (int i = NUM_MASKABLE - 1; i >= 0; i--)
		begin
			if (reqVec[i])
			begin
				hit = 1'b1;
				vecNum = VEC_EXT_FIRST + VEC_W'(i);
			end
		end
	end
endmodule

// *** dv/raee_seq_model.sv ***
module raee_seq_model
	import raee_pkg::*;
(
	// clock
	input  wire logic              mclk,
	// vector fetch
	input  wire logic              vecRead,
	input  wire logic [ADDR_W-1:0] vecAddr,
	output logic [ADDR_W-1:0]      vecData
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [ADDR_W-1:0] noise_ff = 16'h0000;
	// ==========================================
	// vector table image
	// outside a fetch the bus is released, so show noise, never the last word
	always @(posedge mclk)
		noise_ff <= noise_ff + 16'h1357;
	assign vecData = vecRead ? {8'h5a, vecAddr[7:0]} : noise_ff;
endmodule

// *** dv/tb_top.sv ***
module tb_top
	import raee_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic pinRst_b = 1'b1;
	logic pwrOn = 1'b0;
	logic wdOvf = 1'b0;
	logic nmiReq = 1'b0;
	logic abReq = 1'b0;
	logic [NUM_EXT-1:0] extReq = '0;
	logic [NUM_WAKE-1:0] wakeReq = '0;
	logic [NUM_INTERNAL-1:0] intReq = '0;
	logic instrDone = 1'b0;
	logic maskWrEn = 1'b0;
	logic maskVal = 1'b0;
	logic [ADDR_W-1:0] vecData, vecAddr, pcValue;
	logic coreHalt, initPulse, stackSave, vecRead, pcLoad, intMask;
	logic [VEC_W-1:0] activeVec;
	int numErrors = 0;
	int totalChecks = 0;
	int initCount = 0;
	always #5 mclk = ~mclk;
	// counts init cycles, so each reset can be shown to pass through the init step
	always @(posedge mclk)
		if (initPulse === 1'b1)
			initCount <= initCount + 1;
	raee_core u_raee_core (.mclk(mclk), .rst_b(rst_b), .externalResetInputLow_b(pinRst_b),
		.powerOnDetect(pwrOn), .watchdogOverflow(wdOvf), .nmiReq(nmiReq), .addrBreakReq(abReq),
		.extReq(extReq), .wakeReq(wakeReq), .internalReq(intReq), .instrDone(instrDone),
		.maskWrEn(maskWrEn), .maskWrVal(maskVal), .vecData(vecData), .coreHalt(coreHalt),
		.initPulse(initPulse), .stackSave(stackSave), .vecRead(vecRead), .vecAddr(vecAddr),
		.pcLoad(pcLoad), .pcValue(pcValue), .intMask(intMask), .activeVec(activeVec));
	raee_seq_model u_raee_seq_model (.mclk(mclk), .vecRead(vecRead), .vecAddr(vecAddr),
		.vecData(vecData));
	// ==========================================
	// helpers
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		totalChecks++;
		if (got !== exp)
		begin
			numErrors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// n is edges after the taking edge until pcLoad shows; 60 means none
	task automatic waitLoad(output int n);
		for (n = 1; n < 60; n++)
		begin
			@(posedge mclk);
			#1;
			if (pcLoad === 1'b1)
				break;
		end
	endtask
	task automatic step(output int n);
		@(posedge mclk) instrDone <= 1'b1;
		@(posedge mclk) instrDone <= 1'b0;
		waitLoad(n);
	endtask
	// sequencer writes the mask bit; one idle edge precedes each write
	task automatic wrMask(input logic v);
		@(posedge mclk);
		maskWrEn <= 1'b1;
		maskVal <= v;
		@(posedge mclk) maskWrEn <= 1'b0;
	endtask
	task automatic svc(input int v, input bit clr);
		int n;
		if (clr)
			wrMask(1'b0);
		step(n);
		chk(n, 6);
		chk(activeVec, v);
		chk(pcValue, {8'h5a, 1'b0, v[5:0], 1'b0});
		chk(intMask, 1'b1);
		// the source drops its request once serviced
		@(posedge mclk);
		if (v == 3) nmiReq <= 1'b0;
		else if (v == 5) abReq <= 1'b0;
		else if (v < 11) extReq[v-6] <= 1'b0;
		else if (v < 19) wakeReq[v-11] <= 1'b0;
		else intReq[v-19] <= 1'b0;
	endtask
	// ==========================================
	// scenarios
	task automatic resetBy(input int src);
		int n;
		int k;
		@(posedge mclk);
		case (src)
			0: pinRst_b <= 1'b0;
			1: pwrOn <= 1'b1;
			default: wdOvf <= 1'b1;
		endcase
		repeat (4) @(posedge mclk);
		#1;
		chk(coreHalt, 1'b1);
		@(posedge mclk);
		k = initCount;
		pinRst_b <= 1'b1;
		pwrOn <= 1'b0;
		wdOvf <= 1'b0;
		waitLoad(n);
		chk(n, 4);
		chk(initCount - k, 1);
		chk(pcValue, 16'h5a00);
		chk(intMask, 1'b1);
		@(posedge mclk) nmiReq <= 1'b1;
		waitLoad(n);
		chk(n, 60);
		// the first boundary after reset must not take even the non-maskable request
		step(n);
		chk(n, 60);
		@(posedge mclk) nmiReq <= 1'b0;
	endtask
	task automatic scnMask();
		int n;
		@(posedge mclk);
		nmiReq <= 1'b1;
		abReq <= 1'b1;
		extReq[0] <= 1'b1;
		svc(3, 0);
		svc(5, 0);
		step(n);
		chk(n, 60);
		svc(6, 1);
	endtask
	task automatic scnPrio();
		int n;
		int exp[5] = '{8, 11, 18, 19, 43};
		@(posedge mclk);
		extReq[2] <= 1'b1;
		wakeReq[0] <= 1'b1;
		wakeReq[7] <= 1'b1;
		intReq[0] <= 1'b1;
		intReq[24] <= 1'b1;
		wrMask(1'b0);
		#1;
		chk(intMask, 1'b0);
		wrMask(1'b1);
		#1;
		chk(intMask, 1'b1);
		// mask written back to one: every pending maskable request waits
		foreach (exp[i])
		begin
			step(n);
			chk(n, 60);
		end
		foreach (exp[i])
			svc(exp[i], 1);
	endtask
	task automatic scnAbort();
		@(posedge mclk) nmiReq <= 1'b1;
		@(posedge mclk) instrDone <= 1'b1;
		@(posedge mclk) instrDone <= 1'b0;
		resetBy(2);
	endtask
	task automatic finalReport();
		$display("checks=%0d errors=%0d", totalChecks, numErrors);
		if (numErrors == 0 && totalChecks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		int n;
		repeat (16) @(posedge mclk);
		rst_b <= 1'b1;
		// let the power-up sequence finish before any pin reset
		waitLoad(n);
		chk(n, 4);
		chk(pcValue, 16'h5a00);
		resetBy(0);
		scnMask();
		scnPrio();
		scnAbort();
		resetBy(1);
		finalReport();
	end
	// a full run needs about 900 cycles
	initial
	begin
		#200us;
		numErrors++;
		finalReport();
	end
endmodule
